// ### hpf_fault_reset.sv
`timescale 1ns/1ps
module hpf_fault_reset
   import hpf_pkg::*;
#(
   parameter int RAMP_CYC = HPF_RAMP_CYC,
   parameter int PERSIST_CYC = HPF_PERSIST_CYC,
   parameter int GOOD_CYC = HPF_GOOD_CYC
)
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic power_request_n,
   input wire logic over_temp,
   input wire hpf_rails_t in_limit,
   input wire logic [1:0] severe_over,
   input wire hpf_rails_t rail_ok,
   input wire logic bus_reset_n,
   output logic switch_on,
   output logic trip_indicator_n,
   output logic rails_good_n,
   output logic local_reset_n
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [9:0] sync_a;
   logic [9:0] sync_b;
   logic req_n;
   logic hot;
   logic bus_rst_n;
   hpf_rails_t lim;
   hpf_rails_t ok;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         // Request idles high and every fault idles low, so reset releases quietly.
         sync_a <= 10'h200;
         sync_b <= 10'h200;
      end
      else
      begin
         sync_a <= {power_request_n, bus_reset_n, over_temp, in_limit, rail_ok[3:1]};
         sync_b <= sync_a;
      end
   end

   logic [1:0] sev_a;
   logic [1:0] sev;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sev_a <= 2'h0;
         sev <= 2'h0;
      end
      else
      begin
         sev_a <= severe_over;
         sev <= sev_a;
      end
   end

   logic ok0_a;
   logic ok0;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ok0_a <= 1'b0;
         ok0 <= 1'b0;
      end
      else
      begin
         ok0_a <= rail_ok[0];
         ok0 <= ok0_a;
      end
   end

   assign req_n = sync_b[9];
   assign bus_rst_n = sync_b[8];
   assign hot = sync_b[7];
   assign lim = sync_b[6:3];
   assign ok = {sync_b[2:0], ok0};

   // ****************************************
   // Sequencer
   // ****************************************
   hpf_state_t state;
   hpf_state_t next_state;
   logic [HPF_CNT_W-1:0] ramp_cnt;
   logic [HPF_CNT_W-1:0] hi_cnt;
   logic [HPF_CNT_W-1:0] lo_cnt;
   logic trip_now;
   logic ramp_done;

   assign ramp_done = (ramp_cnt >= HPF_CNT_W'(RAMP_CYC - 1));

   always_comb
   begin
      trip_now = 1'b0;
      if (hot)
         trip_now = 1'b1;
      if (state == HPF_RAMP && ramp_done && (lim != 4'h0))
         trip_now = 1'b1;
      if (state == HPF_ON)
      begin
         if (hi_cnt >= HPF_CNT_W'(PERSIST_CYC))
            trip_now = 1'b1;
         if (lo_cnt >= HPF_CNT_W'(PERSIST_CYC))
            trip_now = 1'b1;
         if (sev != 2'h0)
            trip_now = 1'b1;
      end
   end

   always_comb
   begin
      next_state = state;
      unique case (state)
         HPF_OFF:
            if (trip_now)
               next_state = HPF_TRIP;
            else if (!req_n)
               next_state = HPF_RAMP;
         HPF_RAMP:
            if (trip_now)
               next_state = HPF_TRIP;
            else if (req_n)
               next_state = HPF_OFF;
            else if (ramp_done)
               next_state = HPF_ON;
         HPF_ON:
            if (trip_now)
               next_state = HPF_TRIP;
            else if (req_n)
               next_state = HPF_OFF;
         HPF_TRIP:
            if (req_n && !hot)
               next_state = HPF_OFF;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         state <= HPF_OFF;
      else
         state <= next_state;
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         ramp_cnt <= '0;
      else if (state == HPF_RAMP && !ramp_done)
         ramp_cnt <= ramp_cnt + 1'b1;
      else if (state != HPF_RAMP)
         ramp_cnt <= '0;
   end

   // Persistence counters restart on any gap in the limit indication.
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hi_cnt <= '0;
         lo_cnt <= '0;
      end
      else
      begin
         if (state == HPF_ON && (lim.p12 || lim.n12))
            hi_cnt <= hi_cnt + 1'b1;
         else
            hi_cnt <= '0;
         if (state == HPF_ON && (lim.p5 || lim.p3))
            lo_cnt <= lo_cnt + 1'b1;
         else
            lo_cnt <= '0;
      end
   end

   // ****************************************
   // Power good and local reset
   // ****************************************
   logic [HPF_CNT_W-1:0] bad_cnt;

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bad_cnt <= '0;
         rails_good_n <= 1'b1;
      end
      else if (&ok)
      begin
         bad_cnt <= '0;
         rails_good_n <= 1'b0;
      end
      else if (bad_cnt >= HPF_CNT_W'(GOOD_CYC))
         rails_good_n <= 1'b1;
      else
         bad_cnt <= bad_cnt + 1'b1;
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         local_reset_n <= 1'b0;
         switch_on <= 1'b0;
         trip_indicator_n <= 1'b1;
      end
      else
      begin
         local_reset_n <= bus_rst_n && !rails_good_n;
         switch_on <= (next_state == HPF_RAMP) || (next_state == HPF_ON);
         trip_indicator_n <= (next_state != HPF_TRIP);
      end
   end

endmodule : hpf_fault_reset

// ### hpf_pkg.sv
// How it works
// - Over-temperature latches all switches off, trips.
// - Limit still active after ramp ends trips.
// - 12V rails limited over 45 us trip.
// - 5V/3.3V overcurrent persisting 45 us trips.
// - 5V/3.3V above three times limit trips instantly after ramp ends.
// - Trip holds until request goes high with over-temperature clear, or reset.
// - Rails not good forces local reset low.
// - Local reset high only bus reset high, good.
// - Rail low over 10 us deasserts good.
// - Request low enables switches, starts ramp window.
// - Limit faults ignored during ramp window.
// - Request high powers down, ends ramp window.
// - Good asserted only when all four rails good.
package hpf_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int HPF_CLK_HZ = 10_000_000;
   localparam int HPF_PERSIST_US = 45;
   localparam int HPF_GOOD_US = 10;
   localparam int HPF_RAMP_US = 52_400;
   localparam int HPF_PERSIST_CYC = HPF_PERSIST_US * (HPF_CLK_HZ / 1_000_000);
   localparam int HPF_GOOD_CYC = HPF_GOOD_US * (HPF_CLK_HZ / 1_000_000);
   localparam int HPF_RAMP_CYC = HPF_RAMP_US * (HPF_CLK_HZ / 1_000_000);
   localparam int HPF_CNT_W = 20;

   // ****************************************
   // Rail indications, one bit per rail
   // ****************************************
   typedef struct packed {
      logic p12;
      logic n12;
      logic p5;
      logic p3;
   } hpf_rails_t;

   localparam hpf_rails_t HPF_RAILS_RESET = 4'h0;

   typedef enum logic [1:0] {
      HPF_OFF = 2'b00,
      HPF_RAMP = 2'b01,
      HPF_ON = 2'b11,
      HPF_TRIP = 2'b10
   } hpf_state_t;

endpackage : hpf_pkg

// ### hpf_checker.sv
`timescale 1ns/1ps
module hpf_checker
   import hpf_pkg::*;
#(
   parameter int RAMP_CYC = 20,
   parameter int GOOD_CYC = 5
)
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic power_request_n,
   input wire logic over_temp,
   input wire hpf_rails_t in_limit,
   input wire logic [1:0] severe_over,
   input wire hpf_rails_t rail_ok,
   input wire logic bus_reset_n,
   input wire logic switch_on,
   input wire logic trip_indicator_n,
   input wire logic rails_good_n,
   input wire logic local_reset_n
);
   int lim_cnt;
   int bad_cnt;
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lim_cnt <= 0;
         bad_cnt <= 0;
      end
      else
      begin
         lim_cnt <= (switch_on && |in_limit) ? lim_cnt + 1 : 0;
         bad_cnt <= (&rail_ok) ? 0 : bad_cnt + 1;
      end
   end
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_hot;
      over_temp [*4];
   endsequence
   sequence s_short;
      (|severe_over) [*3];
   endsequence
   sequence s_req_off;
      power_request_n [*4];
   endsequence
   chk_heat_trip: assert property (s_hot |-> ##[0:3] !trip_indicator_n)
      else $error("heat no trip");
   chk_trip_off: assert property (!trip_indicator_n |-> !switch_on)
      else $error("on while tripped");
   chk_short_trip: assert property (s_short |-> ##[0:3] !trip_indicator_n)
      else $error("short no trip");
   chk_req_down: assert property (s_req_off |-> ##[0:2] !switch_on)
      else $error("no power down");
   chk_lim_bound: assert property (lim_cnt < RAMP_CYC + 8)
      else $error("limit not tripped");
   chk_bad_good: assert property (bad_cnt == GOOD_CYC + 5 |-> rails_good_n)
      else $error("bad rail kept good");
   chk_rst_low: assert property (rails_good_n |=> !local_reset_n)
      else $error("reset not forced");
   chk_rst_high: assert property (local_reset_n |->
      !$past(rails_good_n) && $past(bus_reset_n, 3))
      else $error("reset released early");
endmodule : hpf_checker

bind hpf_fault_reset hpf_checker #(.RAMP_CYC(RAMP_CYC), .GOOD_CYC(GOOD_CYC)) u_chk (
   .sys_clk(sys_clk), .reset_n(reset_n), .power_request_n(power_request_n),
   .over_temp(over_temp), .in_limit(in_limit), .severe_over(severe_over), .rail_ok(rail_ok),
   .bus_reset_n(bus_reset_n),
   .switch_on(switch_on), .trip_indicator_n(trip_indicator_n), .rails_good_n(rails_good_n),
   .local_reset_n(local_reset_n));

// ### hpf_backplane.sv
`timescale 1ns/1ps
module hpf_backplane (
   output logic power_request_n,
   output logic bus_reset_n,
   input wire logic sys_clk
);
   initial
   begin
      power_request_n = 1'b1;
      bus_reset_n = 1'b0;
   end
   task slot(input logic req_n, input int lag);
      repeat (lag + 1) @(negedge sys_clk);
      power_request_n = req_n;
   endtask : slot
   task bus_rst(input logic v);
      @(negedge sys_clk);
      bus_reset_n = v;
   endtask : bus_rst
endmodule : hpf_backplane

// ### tb.sv
`timescale 1ns/1ps
module tb;
   import hpf_pkg::*;
   logic sys_clk, reset_n, over_temp, power_request_n, bus_reset_n;
   logic switch_on, trip_indicator_n, rails_good_n, local_reset_n;
   logic [1:0] severe_over;
   logic [3:0] outs;
   hpf_rails_t in_limit, rail_ok;
   int failures, checked, cycles, i;
   assign outs = {switch_on, trip_indicator_n, rails_good_n, local_reset_n};
   hpf_backplane bp (.sys_clk(sys_clk), .power_request_n(power_request_n),
      .bus_reset_n(bus_reset_n));
   hpf_fault_reset #(.RAMP_CYC(20), .PERSIST_CYC(10), .GOOD_CYC(5)) uut (
      .sys_clk(sys_clk), .reset_n(reset_n), .power_request_n(power_request_n),
      .over_temp(over_temp), .in_limit(in_limit), .severe_over(severe_over),
      .rail_ok(rail_ok), .bus_reset_n(bus_reset_n), .switch_on(switch_on),
      .trip_indicator_n(trip_indicator_n), .rails_good_n(rails_good_n),
      .local_reset_n(local_reset_n));
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles > 4000)
      begin
         failures++;
         finish_test();
      end
   end
   function logic [3:0] mdl(input int on, input int trip, input int bad, input int brst);
      return {on != 0 && trip == 0, trip == 0, bad != 0, bad == 0 && brst != 0};
   endfunction : mdl
   task chk(input logic [3:0] got, input logic [3:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task run(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : run
   task recycle;
      bp.slot(1'b1, $urandom % 3);
      run(8);
      bp.slot(1'b0, $urandom % 3);
      run(40);
      chk(outs, mdl(1, 0, 0, 1));
   endtask : recycle
   task finish_test;
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test
   initial
   begin
      void'($urandom(32'h6969_b49e));
      reset_n = 1'b0;
      over_temp = 1'b0;
      in_limit = HPF_RAILS_RESET;
      severe_over = 2'h0;
      rail_ok = 4'hf;
      run(5);
      reset_n = 1'b1;
      bp.bus_rst(1'b1);
      bp.slot(1'b0, 2);
      run(40);
      chk(outs, mdl(1, 0, 0, 1));
      bp.bus_rst(1'b0);
      run(6);
      chk(outs, mdl(1, 0, 0, 0));
      bp.bus_rst(1'b1);
      run(6);
      for (i = 0; i < 4; i++)
      begin
         in_limit = hpf_rails_t'(4'h1 << i);
         run(1 + $urandom % 6);
         in_limit = HPF_RAILS_RESET;
         run(20);
         chk(outs, mdl(1, 0, 0, 1));
         in_limit = hpf_rails_t'(4'h1 << i);
         run(30);
         in_limit = HPF_RAILS_RESET;
         run(10);
         chk(outs, mdl(1, 1, 0, 1));
         recycle();
      end
      for (i = 0; i < 2; i++)
      begin
         severe_over = 2'(1 + $urandom % 3);
         run(4);
         severe_over = 2'h0;
         run(4);
         chk(outs, mdl(1, 1, 0, 1));
         recycle();
      end
      over_temp = 1'b1;
      run(8);
      chk(outs, mdl(1, 1, 0, 1));
      over_temp = 1'b0;
      recycle();
      bp.slot(1'b1, 0);
      run(8);
      in_limit = hpf_rails_t'(4'h1 << ($urandom % 4));
      bp.slot(1'b0, 1);
      run(12);
      chk(outs, mdl(1, 0, 0, 1));
      run(20);
      chk(outs, mdl(1, 1, 0, 1));
      in_limit = HPF_RAILS_RESET;
      recycle();
      i = $urandom % 4;
      rail_ok = hpf_rails_t'(~(4'h1 << i));
      run(3);
      rail_ok = 4'hf;
      run(2);
      chk(outs, mdl(1, 0, 0, 1));
      rail_ok = hpf_rails_t'(~(4'h1 << i));
      run(12);
      chk(outs, mdl(1, 0, 1, 1));
      rail_ok = 4'hf;
      run(6);
      chk(outs, mdl(1, 0, 0, 1));
      bp.slot(1'b1, 0);
      run(6);
      chk(outs, mdl(0, 0, 0, 1));
      finish_test();
   end
endmodule : tb
